// >>> inc/jk_ms_pkg.sv
package jk_ms_pkg;
   // ------------------------------------------------------------
   // input combining variants
   // ------------------------------------------------------------
   typedef enum logic [0:0] {
      combine_and_or = 1'h0,
      combine_and    = 1'h1
   } combine_type;

   // ------------------------------------------------------------
   // sizes and reset values
   // ------------------------------------------------------------
   localparam int   term_width   = 3;
   localparam int   term_count   = 2;
   localparam logic state_reset  = 1'h0;
   localparam logic master_reset = 1'h0;

   // clock period of mclk in ns (20 MHz)
   localparam int   mclk_period_ns = 50;
endpackage

// >>> hw/jk_master_slave_flip_flop.sv
`timescale 1ns/1ps
// Behaviour
// - isolate slave, load master, block, transfer
// - and-or variant: combined terms enter master
// - and variant: only the first term, anded, enters master
// - low preset forces state to one
// - low clear forces state to zero
// - preset and clear ignore the clock pulse but act on mclk edges
// - hold, reset, set or toggle per j/k
module jk_master_slave_flip_flop
   import jk_ms_pkg::*;
#(
   parameter combine_type combine = combine_and,
   parameter int          width   = term_width,
   parameter int          terms   = term_count
) (
   input  wire logic                           mclk,
   input  wire logic                           srst,
   input  wire logic                           clk_pulse,
   input  wire logic [terms-1:0][width-1:0]    j_in,
   input  wire logic [terms-1:0][width-1:0]    k_in,
   input  wire logic                           preset_n,
   input  wire logic                           clear_n,
   output logic                                q,
   output logic                                q_n
);

   // ------------------------------------------------------------
   // input combining
   // ------------------------------------------------------------
   logic [terms-1:0] j_prod;
   logic [terms-1:0] k_prod;
   logic             j_term;
   logic             k_term;

   for (genvar i = 0; i < terms; i++) begin : g_prod
      assign j_prod[i] = &j_in[i];
      assign k_prod[i] = &k_in[i];
   end

   always_comb begin
      if (combine == combine_and_or) begin
         j_term = |j_prod;
         k_term = |k_prod;
      end else begin
         j_term = j_prod[0];
         k_term = k_prod[0];
      end
   end

   // ------------------------------------------------------------
   // master stage
   // ------------------------------------------------------------
   // sampled clock pulse marks the two phases; pins are synchronous
   logic clk_prev;
   logic master;
   logic slave_state;

   always_ff @(posedge mclk) begin
      if (srst) begin
         clk_prev <= 1'h0;
      end else begin
         clk_prev <= clk_pulse;
      end
   end

   // master loads only on the rising pulse edge, then inputs are blocked
   // while high, so level changes during the pulse cannot leak in
   always_ff @(posedge mclk) begin
      if (srst) begin
         master <= master_reset;
      end else if (clk_pulse && !clk_prev) begin
         case ({j_term, k_term})
            2'h0:    master <= slave_state;
            2'h1:    master <= 1'h0;
            2'h2:    master <= 1'h1;
            2'h3:    master <= ~slave_state;
            default: master <= slave_state;
         endcase
      end
   end

   // ------------------------------------------------------------
   // slave stage and overrides
   // ------------------------------------------------------------
   // preset and clear are sampled each cycle, independent of the pulse;
   // both low gives preset priority, an illegal case on the part anyway
   always_ff @(posedge mclk) begin
      if (srst) begin
         slave_state <= state_reset;
      end else if (!preset_n) begin
         slave_state <= 1'h1;
      end else if (!clear_n) begin
         slave_state <= 1'h0;
      end else if (!clk_pulse && clk_prev) begin
         slave_state <= master;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         q   <= state_reset;
         q_n <= ~state_reset;
      end else if (!preset_n) begin
         q   <= 1'h1;
         q_n <= 1'h0;
      end else if (!clear_n) begin
         q   <= 1'h0;
         q_n <= 1'h1;
      end else if (!clk_pulse && clk_prev) begin
         q   <= master;
         q_n <= ~master;
      end
   end

endmodule // jk_master_slave_flip_flop

// >>> testbench/jk_ms_monitor.sv
`timescale 1ns/1ps
module jk_ms_monitor import jk_ms_pkg::*; (input wire logic mclk, srst, clk_pulse, preset_n, clear_n, q, q_n,
   input wire logic [term_count-1:0][term_width-1:0] j_in, k_in);
   logic pc, pj, pk, pq, ok, fall;
   assign ok = preset_n && clear_n;
   assign fall = pc && !clk_pulse;
   // snapshot at pulse rise; the slave may only take it at the fall
   always_ff @(posedge mclk) pc <= clk_pulse;
   always_ff @(posedge mclk) if (clk_pulse && !pc) {pj, pk, pq} <= {&j_in[0], &k_in[0], q};
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   a_preset_forces: assert property (!preset_n |=> q) else $error("preset");
   a_clear_forces: assert property (preset_n && !clear_n |=> !q) else $error("clear");
   a_outputs_opposite: assert property (q_n == !q) else $error("q_n");
   a_slave_isolated: assert property (ok && !fall |=> $stable(q)) else $error("hold");
   a_hold_case: assert property (ok && fall && !pj && !pk |=> q == pq) else $error("keep");
   a_set_term: assert property (ok && fall && pj && !pk |=> q) else $error("set");
   a_reset_term: assert property (ok && fall && !pj && pk |=> !q) else $error("reset");
   a_toggle_case: assert property (ok && fall && pj && pk |=> q != pq) else $error("toggle");
endmodule // jk_ms_monitor
bind jk_master_slave_flip_flop jk_ms_monitor chk (.*);

// >>> testbench/jk_upstream.sv
`timescale 1ns/1ps
module jk_upstream import jk_ms_pkg::*; (input wire logic mclk, output logic clk_pulse,
   output logic [term_count-1:0][term_width-1:0] j_in, k_in);
   initial {clk_pulse, j_in, k_in} = '0;
   task automatic pulse(input logic [11:0] v);
      @(posedge mclk) #1 {k_in, j_in} = v;
      @(posedge mclk) #1 clk_pulse = 1'h1;
      @(posedge mclk) #1 clk_pulse = 1'h0;
      @(posedge mclk) #1 {k_in, j_in} = ~v; // terms move only once low
   endtask
endmodule // jk_upstream

// >>> testbench/jk_master_slave_flip_flop_bench.sv
`timescale 1ns/1ps
module jk_master_slave_flip_flop_bench import jk_ms_pkg::*;;
   logic mclk = 0, srst = 1, preset_n = 1, clear_n = 1, clk_pulse, q, q_n, e = 0;
   logic [term_count-1:0][term_width-1:0] j_in, k_in;
   logic [11:0] v;
   int fail_count = 0, tests_run = 0;
   jk_upstream src (.*);
   jk_master_slave_flip_flop uut (.*);
   initial forever #(mclk_period_ns / 2) mclk = ~mclk;
   function automatic logic next_q(logic c, logic j, logic k);
      return j && k ? !c : j ? 1'h1 : k ? 1'h0 : c;
   endfunction
   task automatic check();
      tests_run++;
      if (q !== e || q_n !== !e) begin
         fail_count++;
         $display("[ERR] q/q_n expected %b/%b seen %b/%b", e, !e, q, q_n);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #100000 fail_count++;
      summarize();
   end
   initial begin
      void'($urandom(87));
      repeat (16) @(posedge mclk);
      #1 srst = 0;
      check();
      for (int n = 0; n < 100; n++) begin
         v = $urandom;
         v[2:0] |= {3{v[9]}}; // bias so all four j/k cases occur
         v[8:6] |= {3{v[10]}};
         e = next_q(e, &v[2:0], &v[8:6]);
         src.pulse(v);
         check();
      end
      $display("jk done");
      for (int i = 0; i < 3; i++) begin
         {preset_n, clear_n} = 2'(2'h2 >> i);
         e = i > 0;
         @(posedge mclk) #1 check();
      end
      $display("override done");
      summarize();
   end
endmodule // jk_master_slave_flip_flop_bench
